// ### rtl/sleie_top.sv
`timescale 1ns/1ps
`include "sleie_defines.svh"
module sleie_top #(
  parameter int unsigned BLINK_HALF_CYCLES = `SLEIE_BLINK_HALF_NS / `SLEIE_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SLEIE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sleie_pkg::sleie_status_s status,
  output sleie_pkg::sleie_leds_s leds
);
  import sleie_pkg::*;

  logic [`SLEIE_CTRL_W-1:0] ctrl;
  logic [31:0] blink_cnt;
  logic blink_phase;
  logic blink_wrap;
  sleie_leds_s next_leds;

  function automatic sleie_color_e flash(input sleie_color_e c, input logic ph);
    flash = ph ? c : SLEIE_OFF;
  endfunction

  function automatic sleie_color_e port_led(input logic link, input logic act,
                                            input logic ph);
    if (!link) begin
      port_led = SLEIE_OFF;
    end else if (act) begin
      port_led = ph ? SLEIE_ORANGE : SLEIE_GREEN;
    end else begin
      port_led = SLEIE_GREEN;
    end
  endfunction

  function automatic logic mapped(input logic [`SLEIE_ADDR_W-1:0] a);
    mapped = (a == `SLEIE_OFF_CTRL) || (a == `SLEIE_OFF_LED_LO) ||
             (a == `SLEIE_OFF_LED_HI);
  endfunction

  // single divider so every flashing led blinks in phase
  assign blink_wrap = (blink_cnt == BLINK_HALF_CYCLES - 32'h00000001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= 32'h00000000;
    end else if (blink_wrap) begin
      blink_cnt <= 32'h00000000;
    end else begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_phase <= 1'b0;
    end else if (blink_wrap) begin
      blink_phase <= ~blink_phase;
    end
  end

  // apb slave: zero wait states, unmapped offsets answer with pslverr
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SLEIE_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == `SLEIE_OFF_CTRL) begin
      ctrl <= pwdata[`SLEIE_CTRL_W-1:0];
    end
  end

  // read data latched in setup so it stands registered for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      unique case (paddr)
        `SLEIE_OFF_CTRL: begin
          prdata[`SLEIE_CTRL_W-1:0] <= ctrl;
        end
        `SLEIE_OFF_LED_LO: begin
          prdata[`SLEIE_LED_LO_W-1:0] <= {leds.safety_protocol_indicator,
            leds.power_indicator, leds.spare_led, leds.warn2_led, leds.warn3_led,
            leds.warn_led, leds.restart_led, leds.safety_output_led};
        end
        `SLEIE_OFF_LED_HI: begin
          prdata[`SLEIE_LED_HI_W-1:0] <= {leds.port2_link_activity_led,
            leds.port1_link_activity_led, leds.network_led};
          prdata[`SLEIE_PHASE_BIT] <= blink_phase;
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end

  // each chain checks power or link loss first where it has one, then errors, then activity, then idle
  always_comb begin
    next_leds = '0;
    if (!status.powered) begin
      next_leds.safety_output_led = SLEIE_OFF;
    end else if (status.device_error) begin
      next_leds.safety_output_led = flash(SLEIE_RED, blink_phase);
    end else if (status.safety_switching_outputs_on) begin
      next_leds.safety_output_led = SLEIE_GREEN;
    end else begin
      next_leds.safety_output_led = SLEIE_RED;
    end

    // occupied field wins even with the interlock disabled
    if (status.field_occupied) begin
      next_leds.restart_led = flash(SLEIE_YELLOW, blink_phase);
    end else if (ctrl[`SLEIE_CTRL_RI_EN] && status.restart_interlock_locked &&
                 (!ctrl[`SLEIE_CTRL_LINKED] || status.linked_sensor_enabled)) begin
      next_leds.restart_led = SLEIE_YELLOW;
    end else begin
      next_leds.restart_led = SLEIE_OFF;
    end

    next_leds.warn_led = status.warn_field1 ? SLEIE_BLUE : SLEIE_OFF;
    next_leds.warn3_led = (ctrl[`SLEIE_CTRL_FOUR] && status.warn_field3) ?
                          SLEIE_BLUE : SLEIE_OFF;
    next_leds.warn2_led = (ctrl[`SLEIE_CTRL_FOUR] && status.warn_field2) ?
                          flash(SLEIE_YELLOW, blink_phase) : SLEIE_OFF;
    next_leds.spare_led = SLEIE_OFF;

    if (!status.powered) begin
      next_leds.power_indicator = SLEIE_OFF;
    end else if (status.self_test_fail || status.internal_comm_fail) begin
      next_leds.power_indicator = SLEIE_RED;
    end else if (status.locate_active) begin
      next_leds.power_indicator = flash(SLEIE_GREEN, blink_phase);
    end else begin
      next_leds.power_indicator = SLEIE_GREEN;
    end

    if (status.sp_comm_error) begin
      next_leds.safety_protocol_indicator = SLEIE_RED;
    end else if (status.sp_config_fail) begin
      next_leds.safety_protocol_indicator = flash(SLEIE_RED, blink_phase);
    end else if (status.sp_passive || status.locate_active) begin
      next_leds.safety_protocol_indicator = flash(SLEIE_GREEN, blink_phase);
    end else if (status.sp_active) begin
      next_leds.safety_protocol_indicator = SLEIE_GREEN;
    end else begin
      next_leds.safety_protocol_indicator = SLEIE_OFF;
    end

    if (status.bus_error) begin
      next_leds.network_led = SLEIE_RED;
    end else if (status.eth_config_fail || status.no_data || status.invalid_data) begin
      next_leds.network_led = flash(SLEIE_RED, blink_phase);
    end else if (status.topology_error) begin
      next_leds.network_led = flash(SLEIE_ORANGE, blink_phase);
    end else if (status.bus_init || status.locate_active) begin
      next_leds.network_led = flash(SLEIE_GREEN, blink_phase);
    end else if (status.bus_active && status.cyclic_exchange) begin
      next_leds.network_led = SLEIE_GREEN;
    end else begin
      next_leds.network_led = SLEIE_OFF;
    end

    next_leds.port1_link_activity_led = port_led(status.port_link[0],
      status.port_activity[0], blink_phase);
    next_leds.port2_link_activity_led = port_led(status.port_link[1],
      status.port_activity[1], blink_phase);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leds <= '0;
    end else begin
      leds <= next_leds;
    end
  end

  sequence s_wrap;
    blink_wrap;
  endsequence

  sequence s_port1_busy;
    status.port_link[0] && status.port_activity[0];
  endsequence

  sequence s_ri_ready;
    ctrl[`SLEIE_CTRL_RI_EN] && status.restart_interlock_locked && !status.field_occupied &&
    (!ctrl[`SLEIE_CTRL_LINKED] || status.linked_sensor_enabled);
  endsequence

  a_led1_error: assert property (@(posedge pclk) disable iff (!presetn)
    status.powered && status.device_error |=>
    leds.safety_output_led == ($past(blink_phase) ? SLEIE_RED : SLEIE_OFF))
    else $error("led1 not flashing red on error");

  a_led1_green: assert property (@(posedge pclk) disable iff (!presetn)
    status.powered && !status.device_error && status.safety_switching_outputs_on |=>
    leds.safety_output_led == SLEIE_GREEN)
    else $error("led1 not green with outputs on");

  a_led2_dark: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[`SLEIE_CTRL_RI_EN] && !status.field_occupied |=> leds.restart_led == SLEIE_OFF)
    else $error("led2 lit with interlock disabled");

  a_led2_occupied: assert property (@(posedge pclk) disable iff (!presetn)
    status.field_occupied |=>
    leds.restart_led == ($past(blink_phase) ? SLEIE_YELLOW : SLEIE_OFF))
    else $error("led2 not flashing on occupied field");

  a_led2_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_ri_ready |=> leds.restart_led == SLEIE_YELLOW)
    else $error("led2 not steady yellow when unlockable");

  a_warn_blue: assert property (@(posedge pclk) disable iff (!presetn)
    status.warn_field1 |=> leds.warn_led == SLEIE_BLUE)
    else $error("led3 not blue on warning field");

  a_four_field: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[`SLEIE_CTRL_FOUR] |=> leds.warn3_led == SLEIE_OFF && leds.warn2_led == SLEIE_OFF)
    else $error("four-field leds lit outside four-field mode");

  a_spare_dark: assert property (@(posedge pclk) disable iff (!presetn)
    leds.spare_led == SLEIE_OFF)
    else $error("led6 lit");

  a_power_red: assert property (@(posedge pclk) disable iff (!presetn)
    status.powered && status.self_test_fail |=> leds.power_indicator == SLEIE_RED)
    else $error("power indicator not red on self test fail");

  a_sp_error: assert property (@(posedge pclk) disable iff (!presetn)
    status.sp_comm_error |=> leds.safety_protocol_indicator == SLEIE_RED)
    else $error("protocol led not red on comm error");

  a_net_busfault: assert property (@(posedge pclk) disable iff (!presetn)
    status.bus_error |=> leds.network_led == SLEIE_RED)
    else $error("network led not red on bus error");

  a_port_alternate: assert property (@(posedge pclk) disable iff (!presetn)
    s_port1_busy |=>
    leds.port1_link_activity_led == ($past(blink_phase) ? SLEIE_ORANGE : SLEIE_GREEN))
    else $error("port1 led not alternating on traffic");

  a_blink_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    s_wrap |=> blink_phase != $past(blink_phase) && blink_cnt == 32'h00000000)
    else $error("blink phase did not toggle at wrap");

  a_blink_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !blink_wrap |=> $stable(blink_phase))
    else $error("blink phase moved between wraps");

  // no network fault of any kind pending
  logic net_clean;
  assign net_clean = !status.bus_error && !status.eth_config_fail && !status.no_data &&
                     !status.invalid_data && !status.topology_error;

  a_led1_off: assert property (@(posedge pclk) disable iff (!presetn)
    !status.powered |=> leds.safety_output_led == SLEIE_OFF)
    else $error("led1 lit while powered down");

  a_led1_red: assert property (@(posedge pclk) disable iff (!presetn)
    status.powered && !status.device_error && !status.safety_switching_outputs_on |=>
    leds.safety_output_led == SLEIE_RED)
    else $error("led1 not red with outputs off");

  a_led2_released: assert property (@(posedge pclk) disable iff (!presetn)
    !status.restart_interlock_locked && !status.field_occupied |=> leds.restart_led == SLEIE_OFF)
    else $error("led2 lit with interlock released");

  a_led2_unlinked: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[`SLEIE_CTRL_LINKED] && !status.linked_sensor_enabled && !status.field_occupied |=>
    leds.restart_led == SLEIE_OFF)
    else $error("led2 lit with linked sensor disabled");

  a_warn_free: assert property (@(posedge pclk) disable iff (!presetn)
    !status.warn_field1 |=> leds.warn_led == SLEIE_OFF)
    else $error("led3 lit with warning field free");

  a_warn3_blue: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[`SLEIE_CTRL_FOUR] && status.warn_field3 |=> leds.warn3_led == SLEIE_BLUE)
    else $error("led4 not blue on warning field 3");

  a_warn3_free: assert property (@(posedge pclk) disable iff (!presetn)
    !status.warn_field3 |=> leds.warn3_led == SLEIE_OFF)
    else $error("led4 lit with warning field 3 free");

  a_warn2_flash: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[`SLEIE_CTRL_FOUR] && status.warn_field2 |=>
    leds.warn2_led == ($past(blink_phase) ? SLEIE_YELLOW : SLEIE_OFF))
    else $error("led5 not flashing on warning field 2");

  a_power_comm: assert property (@(posedge pclk) disable iff (!presetn)
    status.powered && status.internal_comm_fail |=> leds.power_indicator == SLEIE_RED)
    else $error("power indicator not red on comm fault");

  a_power_off: assert property (@(posedge pclk) disable iff (!presetn)
    !status.powered |=> leds.power_indicator == SLEIE_OFF)
    else $error("power indicator lit while powered down");

  a_power_green: assert property (@(posedge pclk) disable iff (!presetn)
    status.powered && !status.self_test_fail && !status.internal_comm_fail &&
    !status.locate_active |=> leds.power_indicator == SLEIE_GREEN)
    else $error("power indicator not steady green");

  a_power_locate: assert property (@(posedge pclk) disable iff (!presetn)
    status.powered && !status.self_test_fail && !status.internal_comm_fail &&
    status.locate_active |=>
    leds.power_indicator == ($past(blink_phase) ? SLEIE_GREEN : SLEIE_OFF))
    else $error("power indicator not flashing on locate");

  a_sp_dark: assert property (@(posedge pclk) disable iff (!presetn)
    !status.sp_comm_error && !status.sp_config_fail && !status.sp_passive &&
    !status.locate_active && !status.sp_active |=> leds.safety_protocol_indicator == SLEIE_OFF)
    else $error("protocol led lit while idle");

  a_sp_green: assert property (@(posedge pclk) disable iff (!presetn)
    !status.sp_comm_error && !status.sp_config_fail && !status.sp_passive &&
    !status.locate_active && status.sp_active |=>
    leds.safety_protocol_indicator == SLEIE_GREEN)
    else $error("protocol led not steady green");

  a_sp_passive: assert property (@(posedge pclk) disable iff (!presetn)
    !status.sp_comm_error && !status.sp_config_fail &&
    (status.sp_passive || status.locate_active) |=>
    leds.safety_protocol_indicator == ($past(blink_phase) ? SLEIE_GREEN : SLEIE_OFF))
    else $error("protocol led not flashing green");

  a_sp_cfgfail: assert property (@(posedge pclk) disable iff (!presetn)
    !status.sp_comm_error && status.sp_config_fail |=>
    leds.safety_protocol_indicator == ($past(blink_phase) ? SLEIE_RED : SLEIE_OFF))
    else $error("protocol led not flashing red");

  a_net_dark: assert property (@(posedge pclk) disable iff (!presetn)
    net_clean && !status.bus_init && !status.locate_active &&
    !(status.bus_active && status.cyclic_exchange) |=> leds.network_led == SLEIE_OFF)
    else $error("network led lit while inactive");

  a_net_init: assert property (@(posedge pclk) disable iff (!presetn)
    net_clean && (status.bus_init || status.locate_active) |=>
    leds.network_led == ($past(blink_phase) ? SLEIE_GREEN : SLEIE_OFF))
    else $error("network led not flashing green");

  a_net_cyclic: assert property (@(posedge pclk) disable iff (!presetn)
    net_clean && !status.bus_init && !status.locate_active && status.bus_active &&
    status.cyclic_exchange |=> leds.network_led == SLEIE_GREEN)
    else $error("network led not steady green");

  a_net_topology: assert property (@(posedge pclk) disable iff (!presetn)
    !status.bus_error && !status.eth_config_fail && !status.no_data && !status.invalid_data &&
    status.topology_error |=>
    leds.network_led == ($past(blink_phase) ? SLEIE_ORANGE : SLEIE_OFF))
    else $error("network led not flashing orange");

  a_net_datafault: assert property (@(posedge pclk) disable iff (!presetn)
    !status.bus_error && (status.eth_config_fail || status.no_data || status.invalid_data) |=>
    leds.network_led == ($past(blink_phase) ? SLEIE_RED : SLEIE_OFF))
    else $error("network led not flashing red");

  a_port_dark: assert property (@(posedge pclk) disable iff (!presetn)
    !status.port_link[0] |=> leds.port1_link_activity_led == SLEIE_OFF)
    else $error("port1 led lit without link");

  a_port_idle: assert property (@(posedge pclk) disable iff (!presetn)
    status.port_link[1] && !status.port_activity[1] |=>
    leds.port2_link_activity_led == SLEIE_GREEN)
    else $error("port2 led not green on idle link");

  a_port2_alternate: assert property (@(posedge pclk) disable iff (!presetn)
    status.port_link[1] && status.port_activity[1] |=>
    leds.port2_link_activity_led == ($past(blink_phase) ? SLEIE_ORANGE : SLEIE_GREEN))
    else $error("port2 led not alternating on traffic");
endmodule

// ### rtl/sleie_defines.svh
`ifndef SLEIE_DEFINES_SVH
`define SLEIE_DEFINES_SVH
`define SLEIE_ADDR_W 12
`define SLEIE_OFF_CTRL 12'h000
`define SLEIE_OFF_LED_LO 12'h004
`define SLEIE_OFF_LED_HI 12'h008
`define SLEIE_CTRL_RI_EN 0
`define SLEIE_CTRL_FOUR 1
`define SLEIE_CTRL_LINKED 2
`define SLEIE_CTRL_W 3
`define SLEIE_CTRL_RST 3'h0
`define SLEIE_LED_LO_W 24
`define SLEIE_LED_HI_W 9
`define SLEIE_PHASE_BIT 9
`define SLEIE_CLK_NS 50
`define SLEIE_BLINK_HALF_NS 250000000
`endif

// ### rtl/sleie_pkg.sv
package sleie_pkg;
  typedef enum logic [2:0] {
    SLEIE_OFF = 3'h0,
    SLEIE_RED = 3'h1,
    SLEIE_GREEN = 3'h2,
    SLEIE_YELLOW = 3'h3,
    SLEIE_BLUE = 3'h4,
    SLEIE_ORANGE = 3'h5
  } sleie_color_e;

  typedef struct packed {
    logic powered;
    logic safety_switching_outputs_on;
    logic device_error;
    logic field_occupied;
    logic restart_interlock_locked;
    logic linked_sensor_enabled;
    logic warn_field1;
    logic warn_field2;
    logic warn_field3;
    logic self_test_fail;
    logic internal_comm_fail;
    logic locate_active;
    logic sp_active;
    logic sp_passive;
    logic sp_config_fail;
    logic sp_comm_error;
    logic bus_init;
    logic bus_active;
    logic cyclic_exchange;
    logic topology_error;
    logic eth_config_fail;
    logic no_data;
    logic invalid_data;
    logic bus_error;
    logic [1:0] port_link;
    logic [1:0] port_activity;
  } sleie_status_s;

  typedef struct packed {
    sleie_color_e port2_link_activity_led;
    sleie_color_e port1_link_activity_led;
    sleie_color_e network_led;
    sleie_color_e safety_protocol_indicator;
    sleie_color_e power_indicator;
    sleie_color_e spare_led;
    sleie_color_e warn2_led;
    sleie_color_e warn3_led;
    sleie_color_e warn_led;
    sleie_color_e restart_led;
    sleie_color_e safety_output_led;
  } sleie_leds_s;
endpackage

// ### verification/sleie_led_panel.sv
`timescale 1ns/1ps
module sleie_led_panel (
  input wire sleie_pkg::sleie_leds_s leds,
  output logic [10:0] lit
);
  import sleie_pkg::*;
  // an operator sees any colour as lit; no memory, so no flicker is hidden
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      lit[i] = leds[3*i +: 3] != 3'h0;
    end
  end
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "sleie_defines.svh"
module testbench;
  import sleie_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sleie_status_s status;
  sleie_leds_s leds;
  logic [10:0] lit;
  int fails = 0;
  int n_checks = 0;
  logic [27:0] cs_st [9] = '{28'h0, 28'h8000000, 28'hC000000, 28'hA000000, 28'h8C00000,
    28'h8800000, 28'h8004000, 28'h8000100, 28'hFFFFFFF};
  logic [2:0] cs_ct [9] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h5, 3'h5, 3'h7, 3'h0, 3'h7};

  sleie_top #(.BLINK_HALF_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status(status), .leds(leds));
  sleie_led_panel panel_u (.leds(leds), .lit(lit));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // entered just after a rising edge; leaves one idle edge so signals never double-assign
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [5:0] st(input int c);
    return 6'h01 << c;
  endfunction

  function automatic logic [5:0] fl(input int c);
    return st(c) | 6'h01;
  endfunction

  // colour sets an LED may show over a full blink period
  function automatic logic [5:0] want(input sleie_status_s s, input logic [2:0] c, input int i);
    case (i)
      0: return !s.powered ? st(0) : s.device_error ? fl(1)
        : s.safety_switching_outputs_on ? st(2) : st(1);
      1: return s.field_occupied ? fl(3) : (c[0] && s.restart_interlock_locked
        && (!c[2] || s.linked_sensor_enabled)) ? st(3) : st(0);
      2: return s.warn_field1 ? st(4) : st(0);
      3: return (c[1] && s.warn_field3) ? st(4) : st(0);
      4: return (c[1] && s.warn_field2) ? fl(3) : st(0);
      6: return !s.powered ? st(0) : (s.self_test_fail || s.internal_comm_fail) ? st(1)
        : s.locate_active ? fl(2) : st(2);
      7: return s.sp_comm_error ? st(1) : s.sp_config_fail ? fl(1)
        : (s.sp_passive || s.locate_active) ? fl(2) : s.sp_active ? st(2) : st(0);
      8: return s.bus_error ? st(1) : (s.eth_config_fail || s.no_data || s.invalid_data)
        ? fl(1) : s.topology_error ? fl(5) : (s.bus_init || s.locate_active) ? fl(2)
        : (s.bus_active && s.cyclic_exchange) ? st(2) : st(0);
      9, 10: return !s.port_link[i-9] ? st(0) : s.port_activity[i-9] ? 6'h24 : st(2);
      default: return st(0);
    endcase
  endfunction

  task automatic run(input logic [27:0] sv, input logic [2:0] c);
    sleie_status_s s;
    logic [5:0] seen [11];
    logic [5:0] m;
    logic on;
    int ph;
    s = sv;
    apb(1'b1, `SLEIE_OFF_CTRL, {$urandom} & 32'hFFFFFFF8 | 32'(c));
    apb(1'b0, `SLEIE_OFF_CTRL, 32'h0);
    cmp(rd, {29'h0, c});
    status <= s;
    repeat (2) @(posedge pclk);
    foreach (seen[i]) seen[i] = 6'h00;
    // eight samples span both halves of the 8-cycle blink period
    // sample mid-cycle so the registered leds have settled
    repeat (8) begin
      @(negedge pclk);
      ph = -1;
      for (int i = 0; i < 11; i++) begin
        seen[i] |= 6'h01 << leds[3*i +: 3];
        m = want(s, c, i);
        if (m[0] && m != 6'h01 || m == 6'h24) begin
          on = (m == 6'h24) ? (leds[3*i +: 3] == 3'h5) : lit[i];
          if (ph < 0) ph = on;
          else cmp(32'(on), 32'(ph));
        end
      end
    end
    for (int i = 0; i < 11; i++) begin
      cmp(32'(seen[i]), 32'(want(s, c, i)));
    end
    // back onto a rising edge before the next bus transfer
    @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    status = '0;
    void'($urandom(88));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SLEIE_OFF_CTRL, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, `SLEIE_OFF_LED_LO, 32'hFFFFFFFF);
    cmp(32'(er), 32'h0);
    apb(1'b0, `SLEIE_OFF_LED_LO, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    cmp(32'(er), 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd, 32'h0);
    cmp(32'(er), 32'h1);
    for (int j = 0; j < 9; j++) run(cs_st[j], cs_ct[j]);
    repeat (40) run(28'($urandom), 3'($urandom));
    wrap_up();
  end

  // about 800 cycles expected; cut a hang well beyond that
  initial begin
    repeat (6000) @(posedge pclk);
    fails++;
    wrap_up();
  end
endmodule
